// ==== design/adc_seq_pkg.sv ====
// package for the converter sequencer: register map, field layout, timing constants
// assumes a 20 MHz core clock; all cycle counts derive from CLK_HZ
package adc_seq_pkg;
   localparam int CLK_HZ = 20000000;
   // byte addresses on the register bus
   localparam logic [11:0] ADDR_CFG_A = 12'h0000;
   localparam logic [11:0] ADDR_CFG_B = 12'h0004;
   localparam logic [11:0] ADDR_CFG_C = 12'h0008;
   localparam logic [11:0] ADDR_RES_H = 12'h000C;
   localparam logic [11:0] ADDR_RES_L = 12'h0010;
   localparam logic [11:0] ADDR_SAMPLE = 12'h0014;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // config a fields
   localparam int A_PWRUP = 7;
   localparam int A_BUSY = 6;
   localparam int A_CHSEL_LO = 2;
   // config b fields
   localparam int B_DIFF_LO = 6;
   localparam int B_CONT = 5;
   localparam int B_RATE_LO = 2;
   // config c fields
   localparam int C_RES_LO = 6;
   localparam int C_JUST = 5;
   localparam int C_UNDER = 4;
   localparam int C_OVER = 3;
   localparam int C_RANGE = 2;
   // start latency of the busy flag, in cycles of the converter's 16 MHz clock
   localparam int BUSY_DELAY_CYC16 = 4;
   localparam int CONV_CLK_HZ = 16000000;
   localparam int BUSY_DELAY_CYC = (BUSY_DELAY_CYC16 * CLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
   // times in nanoseconds; the slowest sampling rate in samples per second
   localparam int WUP_OFF_NS = 15000;
   localparam int WUP_STBY_NS = 600;
   localparam int ACQ0_NS = 750;
   localparam int ACQ1_NS = 3000;
   localparam int ACQ2_NS = 12000;
   localparam int ACQ3_NS = 36000;
   localparam int CONV0_NS = 1700;
   localparam int CONV1_NS = 1900;
   localparam int CONV2_NS = 2100;
   localparam int CONV3_NS = 2300;
   localparam int PDD1_NS = 6000;
   localparam int PDD2_NS = 24000;
   localparam int RATE0_SPS = 2000;
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * (CLK_HZ / 1000000) + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int WUP_OFF_CYC = ns2cyc(WUP_OFF_NS);
   localparam int WUP_STBY_CYC = ns2cyc(WUP_STBY_NS);
   localparam int ACQ0_CYC = ns2cyc(ACQ0_NS);
   localparam int ACQ1_CYC = ns2cyc(ACQ1_NS);
   localparam int ACQ2_CYC = ns2cyc(ACQ2_NS);
   localparam int ACQ3_CYC = ns2cyc(ACQ3_NS);
   localparam int CONV0_CYC = ns2cyc(CONV0_NS);
   localparam int CONV1_CYC = ns2cyc(CONV1_NS);
   localparam int CONV2_CYC = ns2cyc(CONV2_NS);
   localparam int CONV3_CYC = ns2cyc(CONV3_NS);
   localparam int PDD1_CYC = ns2cyc(PDD1_NS);
   localparam int PDD2_CYC = ns2cyc(PDD2_NS);
   // slowest sampling period; faster rates shift it right
   localparam int RATE0_CYC = CLK_HZ / RATE0_SPS;
   localparam int CNT_W = 16;
   typedef enum logic [1:0] {PWR_OFF, PWR_STBY, PWR_ON} pwr_e;
   typedef struct packed {
      logic cmpDone;
      logic [11:0] code;
   } conv_result_s;
endpackage

// ==== design/adc_conversion_sequencer.sv ====
// conversion sequencer with an AHB-Lite register slave
// assumes one AHB-Lite master, single word transfers; analog core samples on sampleNow
// and holds its code on anaCode until the sequencer's timed conversion_done_irq pulse (modelled outside)
// the sampling timer and the standby timer both run on core_clk alone
`timescale 1ns/1ns
module adc_conversion_sequencer #(
   parameter int RATE0_CYCLES = adc_seq_pkg::RATE0_CYC,
   parameter int WUP_OFF_CYCLES = adc_seq_pkg::WUP_OFF_CYC,
   parameter int PDD2_CYCLES = adc_seq_pkg::PDD2_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [11:0] anaCode,
   output logic conversion_done_irq,
   output logic analogPower,
   output logic analogStandby,
   output logic pinsAnalog,
   output logic samplerConnect,
   output logic sampleNow,
   output logic [3:0] posInput,
   output logic [1:0] negInput,
   output logic [1:0] resolution
);
   typedef enum logic [2:0] {S_IDLE, S_START, S_WAKE, S_ACQ, S_CONV, S_HOLD} seq_e;

   logic [7:0] cfgA_r, cfgB_r, cfgC_r, resH_r, resL_r;
   logic busy_r, under_r, over_r;
   seq_e st_r, st_nxt;
   logic [adc_seq_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [31:0] rateCnt_r, pddCnt_r;
   adc_seq_pkg::pwr_e pwr_r, pwr_nxt;
   logic wrPend_r;
   logic [11:0] wrAddr_r;
   logic [31:0] rdData;

   // bus decode: writes land in the data phase; reads answer with zero wait
   wire logic addrPhase = hsel & hready & htrans[1];
   wire logic wrCfgA = wrPend_r & (wrAddr_r == adc_seq_pkg::ADDR_CFG_A);
   wire logic wrCfgB = wrPend_r & (wrAddr_r == adc_seq_pkg::ADDR_CFG_B);
   wire logic wrCfgC = wrPend_r & (wrAddr_r == adc_seq_pkg::ADDR_CFG_C);
   wire logic pwrup = cfgA_r[adc_seq_pkg::A_PWRUP];
   wire logic startReq = wrCfgA & hwdata[adc_seq_pkg::A_PWRUP];
   wire logic contMode = cfgB_r[adc_seq_pkg::B_CONT];
   wire logic [2:0] rateCode = cfgB_r[adc_seq_pkg::B_RATE_LO +: 3];
   wire logic [1:0] acqCode = cfgB_r[1:0];
   wire logic [1:0] diffCode = cfgB_r[adc_seq_pkg::B_DIFF_LO +: 2];
   wire logic [1:0] resCode = cfgC_r[adc_seq_pkg::C_RES_LO +: 2];
   wire logic rightJust = cfgC_r[adc_seq_pkg::C_JUST];
   wire logic cntZero = (cnt_r == '0);
   wire logic startDone = (st_r == S_START) & cntZero;

   // the core is powered through wakeup, acquisition and conversion
   function automatic logic phaseOn(input seq_e s);
      phaseOn = (s == S_WAKE) | (s == S_ACQ) | (s == S_CONV);
   endfunction

   function automatic logic [adc_seq_pkg::CNT_W-1:0] acqLen(input logic [1:0] c);
      case (c)
         2'd0: acqLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::ACQ0_CYC - 1);
         2'd1: acqLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::ACQ1_CYC - 1);
         2'd2: acqLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::ACQ2_CYC - 1);
         default: acqLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::ACQ3_CYC - 1);
      endcase
   endfunction

   function automatic logic [adc_seq_pkg::CNT_W-1:0] convLen(input logic [1:0] c);
      case (c)
         2'd0: convLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV0_CYC - 1);
         2'd1: convLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV1_CYC - 1);
         2'd2: convLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV2_CYC - 1);
         default: convLen = adc_seq_pkg::CNT_W'(adc_seq_pkg::CONV3_CYC - 1);
      endcase
   endfunction

   // wakeup depends on whether the core was fully off or in standby
   wire logic [adc_seq_pkg::CNT_W-1:0] wupLen = (pwr_r == adc_seq_pkg::PWR_OFF) ?
      adc_seq_pkg::CNT_W'(WUP_OFF_CYCLES - 1) :
      adc_seq_pkg::CNT_W'(adc_seq_pkg::WUP_STBY_CYC - 1);

   // sampling period; reserved codes fall back to the slowest rate
   wire logic [31:0] ratePeriod = rateCode[2] ? 32'(RATE0_CYCLES) :
      32'(RATE0_CYCLES) >> rateCode[1:0];

   // result masking to the selected width, then justification
   function automatic logic [11:0] maskFor(input logic [1:0] r);
      case (r)
         2'd0: maskFor = 12'h03F;
         2'd1: maskFor = 12'h0FF;
         2'd2: maskFor = 12'h3FF;
         default: maskFor = 12'hFFF;
      endcase
   endfunction
   wire logic [11:0] widthMask = maskFor(resCode);
   // both codings come straight out of the analog core's comparator ladder; offset
   // binary is the natural output with the inverting input as the midpoint
   wire logic [11:0] codeR = (anaCode >> (4'd12 - {1'b0, resCode, 1'b0} - 4'd6)) & widthMask;
   wire logic [15:0] codeL = 16'(codeR) << (4'd10 - {1'b0, resCode, 1'b0});
   wire logic [15:0] resWord = rightJust ? 16'(codeR) : codeL;
   wire logic isZero = (codeR == 12'h000);
   wire logic isFull = (codeR == widthMask);

   // a start in the same cycle wins over the end of the old conversion
   wire logic convEnd = (st_r == S_CONV) & cntZero & ~startReq;
   wire logic acqEnd = (st_r == S_ACQ) & cntZero & ~startReq;
   // continuous mode only ticks while powered up
   wire logic rateTick = contMode & pwrup & (rateCnt_r == 32'd0);
   // single step with delay codes 1 to 3 parks in standby; everything else powers off
   wire logic holdAfter = ~contMode & ((rateCode == 3'd1) | (rateCode == 3'd2) |
      (rateCode == 3'd3));
   // standby delay to full power-down
   wire logic [31:0] pddLoad = (rateCode == 3'd1) ? 32'(adc_seq_pkg::PDD1_CYC - 1) :
      32'(PDD2_CYCLES - 1);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cntZero ? cnt_r : cnt_r - 1'b1;
      pwr_nxt = pwr_r;
      if (startReq) begin
         st_nxt = S_START;
         cnt_nxt = adc_seq_pkg::CNT_W'(adc_seq_pkg::BUSY_DELAY_CYC - 1);
      end else if (!pwrup) begin
         st_nxt = S_IDLE;
         pwr_nxt = adc_seq_pkg::PWR_OFF;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (rateTick) begin
                  st_nxt = S_START;
                  cnt_nxt = adc_seq_pkg::CNT_W'(adc_seq_pkg::BUSY_DELAY_CYC - 1);
               end
            end
            S_START: begin
               if (cntZero) begin
                  st_nxt = S_WAKE;
                  cnt_nxt = wupLen;
               end
            end
            S_WAKE: begin
               if (cntZero) begin
                  st_nxt = S_ACQ;
                  pwr_nxt = adc_seq_pkg::PWR_ON;
                  cnt_nxt = acqLen(acqCode);
               end
            end
            S_ACQ: begin
               if (cntZero) begin
                  st_nxt = S_CONV;
                  cnt_nxt = convLen(resCode);
               end
            end
            S_CONV: begin
               if (cntZero) begin
                  // continuous mode and delay code 0 power off straight away
                  if (!holdAfter) begin
                     st_nxt = S_IDLE;
                     pwr_nxt = adc_seq_pkg::PWR_OFF;
                  end else begin
                     st_nxt = S_HOLD;
                     pwr_nxt = adc_seq_pkg::PWR_STBY;
                  end
               end
            end
            S_HOLD: begin
               // code 011 holds standby until software drops power-up
               if (rateCode == 3'd3) begin
                  st_nxt = S_HOLD;
               end else if (pddCnt_r == 32'd0) begin
                  st_nxt = S_IDLE;
                  pwr_nxt = adc_seq_pkg::PWR_OFF;
               end
            end
            default: st_nxt = S_IDLE;
         endcase
      end
   end

   // bus read mux; busy and range flags read live state, not stored bits
   always_comb begin
      rdData = 32'h0000_0000;
      case (haddr)
         adc_seq_pkg::ADDR_CFG_A: rdData = {24'h00_0000, cfgA_r[7], busy_r, cfgA_r[5:0]};
         adc_seq_pkg::ADDR_CFG_B: rdData = {24'h00_0000, cfgB_r};
         adc_seq_pkg::ADDR_CFG_C: rdData = {24'h00_0000, cfgC_r[7:5], under_r, over_r,
            under_r | over_r, 2'b00};
         adc_seq_pkg::ADDR_RES_H: rdData = {24'h00_0000, resH_r};
         adc_seq_pkg::ADDR_RES_L: rdData = {24'h00_0000, resL_r};
         default: rdData = 32'h0000_0000;
      endcase
   end

   // a write is held one cycle so its data phase lines up with hwdata
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 12'h000;
      end else begin
         wrPend_r <= addrPhase & hwrite;
         wrAddr_r <= haddr;
      end
   end

   // read data is latched in the address phase so it stands for the whole data phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addrPhase & ~hwrite) begin
         hrdata <= rdData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfgA_r <= adc_seq_pkg::CFG_RESET;
         cfgB_r <= adc_seq_pkg::CFG_RESET;
         cfgC_r <= adc_seq_pkg::CFG_RESET;
      end else begin
         if (wrCfgA) begin
            cfgA_r <= hwdata[7:0];
         end
         if (wrCfgB) begin
            cfgB_r <= hwdata[7:0];
         end
         // config c keeps only its writable bits; the flag bits read from live state
         if (wrCfgC) begin
            cfgC_r <= {hwdata[7:5], 5'b00000};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= S_IDLE;
         cnt_r <= '0;
         pwr_r <= adc_seq_pkg::PWR_OFF;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   // sampling-rate timer restarts at each start so periods line up with conversions
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rateCnt_r <= 32'd0;
      end else if (!contMode || !pwrup || startReq || rateTick) begin
         rateCnt_r <= ratePeriod - 32'd1;
      end else if (rateCnt_r != 32'd0) begin
         rateCnt_r <= rateCnt_r - 32'd1;
      end
   end

   // standby hold timer, loaded at conversion end; only read in the hold state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pddCnt_r <= 32'd0;
      end else if (convEnd) begin
         pddCnt_r <= pddLoad;
      end else if (pddCnt_r != 32'd0) begin
         pddCnt_r <= pddCnt_r - 32'd1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
         conversion_done_irq <= 1'b0;
      end else begin
         conversion_done_irq <= convEnd;
         // an abort clears busy at once; it rises again after the start delay
         if (startReq) begin
            busy_r <= 1'b0;
         end else if (convEnd) begin
            busy_r <= 1'b0;
         end else if (startDone) begin
            busy_r <= 1'b1;
         end
      end
   end

   // result bytes and range flags move together with the busy clear at conversion end, not on an abort
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         resH_r <= 8'h00;
         resL_r <= 8'h00;
         under_r <= 1'b0;
         over_r <= 1'b0;
      end else if (convEnd) begin
         resH_r <= resWord[15:8];
         resL_r <= resWord[7:0];
         under_r <= isZero;
         over_r <= isFull;
      end
   end

   // power and sampler controls follow the next state so they switch on the phase edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         analogPower <= 1'b0;
         analogStandby <= 1'b0;
         pinsAnalog <= 1'b0;
         samplerConnect <= 1'b0;
         sampleNow <= 1'b0;
      end else begin
         analogPower <= phaseOn(st_nxt);
         analogStandby <= (st_nxt == S_HOLD);
         pinsAnalog <= pwrup;
         samplerConnect <= (st_nxt == S_ACQ);
         sampleNow <= acqEnd;
      end
   end

   // input routing and resolution are plain copies of the settings
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         posInput <= 4'h0;
         negInput <= 2'b00;
         resolution <= 2'b00;
      end else begin
         posInput <= cfgA_r[adc_seq_pkg::A_CHSEL_LO +: 4];
         negInput <= diffCode;
         resolution <= resCode;
      end
   end

   // the slave never stretches a transfer and never errors; kept in flops so the
   // bus outputs come straight from registers like every other output
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule // adc_conversion_sequencer

// ==== sim/analog_core_model.sv ====
// behavioural analog core: takes the bench's code at the sample instant
// assumes the sequencer reads anaCode before the done pulse that follows
`timescale 1ns/1ns
module analog_core_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sampleNow,
   input wire logic conversion_done_irq,
   input wire logic [11:0] nextCode,
   output logic [11:0] anaCode
);
   logic [11:0] held_r;
   logic conv_r;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         conv_r <= 1'b0;
         held_r <= 12'h000;
      end else if (sampleNow) begin
         held_r <= nextCode;
         conv_r <= 1'b1;
      end else if (conversion_done_irq) begin
         conv_r <= 1'b0;
      end
   end
   // outside a conversion the code is inverted so a stale read shows up
   assign anaCode = conv_r ? held_r : ~held_r;
endmodule // analog_core_model

// ==== sim/adc_conversion_sequencer_props.sv ====
// checker for the sequencer's phase and bus outputs
// assumes the bind below; sees only top module ports
`timescale 1ns/1ns
module adc_seq_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic conversion_done_irq,
   input wire logic analogPower,
   input wire logic pinsAnalog,
   input wire logic samplerConnect,
   input wire logic sampleNow
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   property p_bus;
      hreadyout && !hresp;
   endproperty
   a_bus: assert property (p_bus) else $error("bus not ready or error");
   property p_sample;
      sampleNow |-> $past(samplerConnect) ##1 !samplerConnect;
   endproperty
   a_sample: assert property (p_sample) else $error("sample outside acquisition");
   property p_irq;
      conversion_done_irq |=> !conversion_done_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("done pulse too long");
   property p_power;
      samplerConnect |-> analogPower;
   endproperty
   a_power: assert property (p_power) else $error("acquire while unpowered");
   property p_pins;
      conversion_done_irq |-> pinsAnalog;
   endproperty
   a_pins: assert property (p_pins) else $error("pins left analog setup");
   property p_acq;
      disable iff (sys_rst || !pinsAnalog) $rose(samplerConnect) |-> samplerConnect[*8];
   endproperty
   a_acq: assert property (p_acq) else $error("acquisition too short");
   property p_conv;
      disable iff (sys_rst || !pinsAnalog) sampleNow |-> ##[30:50] conversion_done_irq;
   endproperty
   a_conv: assert property (p_conv) else $error("conversion time wrong");
   property p_wake;
      disable iff (sys_rst || !pinsAnalog) $rose(analogPower) |-> !samplerConnect[*8];
   endproperty
   a_wake: assert property (p_wake) else $error("wakeup too short");
   c_done: cover property (conversion_done_irq);
   c_sample: cover property (sampleNow);
   c_off: cover property ($fell(analogPower));
endmodule // adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker chk (.core_clk, .sys_rst, .hreadyout, .hresp,
   .conversion_done_irq, .analogPower, .pinsAnalog, .samplerConnect, .sampleNow);

// ==== sim/tb_adc_conversion_sequencer.sv ====
// bench for the sequencer: AHB-Lite register tasks and conversion scenarios
// assumes the analog core model beside the design and shortened wake/rate counts
`timescale 1ns/1ns
module tb_adc_conversion_sequencer;
   logic core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready;
   logic [11:0] haddr = 12'h000, anaCode, nextCode = 12'h000;
   logic [1:0] htrans = 2'b00, negInput, resolution;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
   logic hreadyout, hresp, irq, analogPower, analogStandby, pinsAnalog, samplerConnect, sampleNow;
   logic [3:0] posInput;
   logic [11:0] codes [3] = '{12'hFFF, 12'h000, 12'h800};
   logic [31:0] expH [3] = '{32'h0000_00FF, 32'h0000_0000, 32'h0000_0080};
   logic [31:0] expC [3] = '{32'h0000_00CC, 32'h0000_00D4, 32'h0000_00C0};
   int rateN [3] = '{4, 7, 13};
   int err_count = 0, checks = 0, n;
   always #25 core_clk = ~core_clk;
   assign hready = hreadyout;
   adc_conversion_sequencer #(.RATE0_CYCLES(400), .WUP_OFF_CYCLES(20), .PDD2_CYCLES(480)) dut (
      .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .anaCode, .conversion_done_irq(irq), .analogPower, .analogStandby,
      .pinsAnalog, .samplerConnect, .sampleNow, .posInput, .negInput, .resolution);
   analog_core_model core (.core_clk, .sys_rst, .sampleNow, .conversion_done_irq(irq),
      .nextCode, .anaCode);
   task final_report;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task fail_out;
      err_count++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report;
   endtask
   task rdy;
      int i;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
         if (i > 20) fail_out;
      end while (hready !== 1'b1);
   endtask
   // one single word transfer; read data lands in rd
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      rdy;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task cycles(input int c, output int cnt);
      cnt = 0;
      repeat (c) begin
         @(posedge core_clk);
         #1;
         if (irq === 1'b1) cnt++;
      end
   endtask
   // which 0 waits for the done pulse, 1 for the sampler to connect
   task wait_on(input int which, output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         #1;
         c++;
         if (c > 3000) fail_out;
      end while ((which == 0 ? irq : samplerConnect) !== 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 5; a++) begin
         ahb(1'b0, 12'(a * 4), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
      end
      ahb(1'b1, 12'h100, 32'h0000_00FF);
      ahb(1'b0, 12'h100, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_B, 32'h0000_0040);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_C, 32'h0000_00C0);
      for (int k = 0; k < 3; k++) begin
         nextCode <= codes[k];
         ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
         cycles(4, n);
         chk({posInput, negInput, resolution}, 32'h0000_00E7);
         ahb(1'b0, adc_seq_pkg::ADDR_CFG_A, 32'h0000_0000);
         chk(rd, 32'h0000_00F8);
         wait_on(0, n);
         cycles(2, n);
         chk({analogPower, analogStandby, pinsAnalog}, 32'h0000_0001);
         ahb(1'b0, adc_seq_pkg::ADDR_CFG_A, 32'h0000_0000);
         chk(rd, 32'h0000_00B8);
         ahb(1'b0, adc_seq_pkg::ADDR_RES_H, 32'h0000_0000);
         chk(rd, expH[k]);
         ahb(1'b0, adc_seq_pkg::ADDR_CFG_C, 32'h0000_0000);
         chk(rd, expC[k]);
      end
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_B, 32'h0000_0040);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_C, 32'h0000_00C0);
      cycles(200, n);
      chk(n, 0);
      chk(analogPower, 32'h0000_0000);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
      cycles(6, n);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
      cycles(2500, n);
      chk(n, 1);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_B, 32'h0000_004C);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
      wait_on(0, n);
      cycles(50, n);
      chk({analogPower, analogStandby}, 32'h0000_0001);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
      wait_on(1, n);
      chk(n >= 12 && n <= 17, 1);
      wait_on(0, n);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_0000);
      cycles(3, n);
      chk({pinsAnalog, analogStandby}, 32'h0000_0000);
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_C, 32'h0000_0020);
      nextCode <= 12'h800;
      ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
      wait_on(0, n);
      ahb(1'b0, adc_seq_pkg::ADDR_RES_L, 32'h0000_0000);
      chk(rd, 32'h0000_0020);
      for (int r = 0; r < 3; r++) begin
         ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_0000);
         ahb(1'b1, adc_seq_pkg::ADDR_CFG_B, 32'h0000_0060 | (32'(r) << 2));
         ahb(1'b1, adc_seq_pkg::ADDR_CFG_A, 32'h0000_00B8);
         cycles(1350, n);
         chk(n, rateN[r]);
      end
      final_report;
   end
endmodule // tb_adc_conversion_sequencer
